// file: design/hbr_device.sv
// buffer ram device end: command decode, word ports, pointers, status
// Notes on behaviour
// RULE1: first iso buffer pending byte count readable
// RULE2: code 2EH reads second iso pending count
// RULE3: driver loads counter from readback length first
// RULE4: iso port: even byte high, odd low
// RULE5: iso port read 40H, write C0H
// RULE6: driver sets count, checks status before access
// RULE7: port command once, then word accesses only
// RULE8: iso pointer advances two per word
// RULE9: end-of-transfer only at count: irq bit, status
// RULE10: counter counts bytes, accesses move words
// RULE11: ack port: odd byte high, even low
// RULE12: ack port read 41H, write C1H
// RULE13: ack pointer advances two, then end-of-transfer
// RULE14: core clock is multiplied six megahertz reference
// RULE15: ack done flag set once controller read
// RULE16: every new command restarts pointer at zero
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module hbr_device #(
  parameter int DEPTH = hbr_pkg::RAM_BYTES
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  hbr_link_if.dev          link,
  input  wire logic [15:0] iso0_pending_bytes,
  input  wire logic [15:0] iso1_pending_bytes,
  input  wire logic        ack_read_by_hc,
  input  wire logic        ack_refilled,
  output logic             end_pulse,
  output logic [5:0]       buf_status
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    hbr_pkg::hbr_dmode_t          mode;
    logic [7:0]                   code;
    logic [15:0]                  ptr;
    logic [15:0]                  cnt;
    logic [15:0]                  irq_reg;
    logic [hbr_pkg::ST_BITS-1:0]  stat;
    logic [15:0]                  rb0;
    logic [15:0]                  rb1;
    logic [15:0]                  rdata;
    logic                         rvalid;
    logic                         irq;
    logic                         xend;
    logic [DEPTH-1:0][7:0]        iso_mem;
    logic [DEPTH-1:0][7:0]        ack_mem;
  } hbr_dstate_t;

  hbr_dstate_t st;
  hbr_dstate_t next_st;

  // word read from a byte array; hi_even picks which byte lands high
  function automatic logic [15:0] word_get(
    input logic [DEPTH-1:0][7:0] mem,
    input logic [15:0]           p,
    input logic                  hi_even
  );
    logic [AW-1:0] a0;
    logic [AW-1:0] a1;
    a0 = p[AW-1:0];
    a1 = AW'(p + 16'h0001);
    if (hi_even) begin
      word_get = {mem[a0], mem[a1]};
    end else begin
      word_get = {mem[a1], mem[a0]};
    end
  endfunction : word_get

  // word write into a byte array, same lane convention as word_get
  function automatic logic [DEPTH-1:0][7:0] word_put(
    input logic [DEPTH-1:0][7:0] mem,
    input logic [15:0]           p,
    input logic [15:0]           w,
    input logic                  hi_even
  );
    logic [DEPTH-1:0][7:0] m;
    logic [AW-1:0]         a0;
    logic [AW-1:0]         a1;
    m  = mem;
    a0 = p[AW-1:0];
    a1 = AW'(p + 16'h0001);
    m[a0] = hi_even ? w[15:8] : w[7:0];
    m[a1] = hi_even ? w[7:0]  : w[15:8];
    word_put = m;
  endfunction : word_put

  // register read by command code; unknown codes read as zero
  function automatic logic [15:0] reg_get(
    input hbr_dstate_t s,
    input logic [7:0]  c
  );
    case (c)
      hbr_pkg::CMD_RB0_RD:  reg_get = s.rb0; // [RULE1]
      hbr_pkg::CMD_RB1_RD:  reg_get = s.rb1; // [RULE2]
      hbr_pkg::CMD_STAT_RD: reg_get = 16'(s.stat);
      hbr_pkg::CMD_CNT_RD:  reg_get = s.cnt;
      hbr_pkg::CMD_IRQ_RD:  reg_get = s.irq_reg;
      default:              reg_get = hbr_pkg::ZERO16;
    endcase
  endfunction : reg_get

  logic        port_rd;
  logic        port_wr;
  logic        is_iso;
  logic [15:0] ptr_inc;

  // next state: command decode, data phase, pointer and flags
  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    next_st.rdata  = hbr_pkg::ZERO16;
    next_st.xend   = 1'b0;
    next_st.rb0    = iso0_pending_bytes;
    next_st.rb1    = iso1_pending_bytes;
    is_iso  = (st.mode == hbr_pkg::HBR_D_ISO_RD) ||
              (st.mode == hbr_pkg::HBR_D_ISO_WR);
    port_rd = link.rd_stb && ((st.mode == hbr_pkg::HBR_D_ISO_RD) ||
                              (st.mode == hbr_pkg::HBR_D_ACK_RD));
    port_wr = link.wr_stb && ((st.mode == hbr_pkg::HBR_D_ISO_WR) ||
                              (st.mode == hbr_pkg::HBR_D_ACK_WR));
    ptr_inc = st.ptr + hbr_pkg::WORD_BYTES; // [RULE8] [RULE13]

    // register writes: byte count load, or software clear of the interrupt register, write one to clear
    if (st.mode == hbr_pkg::HBR_D_REG && link.wr_stb) begin
      if (st.code == hbr_pkg::CMD_CNT_WR) begin
        next_st.cnt = link.wr_data; // byte count, not words [RULE10]
      end else if (st.code == hbr_pkg::CMD_IRQ_WR) begin
        next_st.irq_reg = st.irq_reg & ~link.wr_data;
      end
      next_st.mode = hbr_pkg::HBR_D_IDLE;
    end
    if (st.mode == hbr_pkg::HBR_D_REG && link.rd_stb) begin
      next_st.rdata  = reg_get(st, st.code);
      next_st.rvalid = 1'b1;
      next_st.mode   = hbr_pkg::HBR_D_IDLE;
    end

    // word ports: iso puts the even byte high, ack the odd byte
    if (port_rd) begin
      next_st.rdata  = is_iso ? word_get(st.iso_mem, st.ptr, 1'b1)  // [RULE4]
                              : word_get(st.ack_mem, st.ptr, 1'b0); // [RULE11]
      next_st.rvalid = 1'b1;
    end
    if (port_wr) begin
      if (is_iso) begin
        next_st.iso_mem = word_put(st.iso_mem, st.ptr, link.wr_data,
                                   1'b1); // [RULE4]
      end else begin
        next_st.ack_mem = word_put(st.ack_mem, st.ptr, link.wr_data,
                                   1'b0); // [RULE11]
      end
    end

    // an odd count ends on the word that covers its last byte
    if (port_rd || port_wr) begin
      next_st.ptr = ptr_inc; // [RULE8] [RULE13]
      if (ptr_inc >= st.cnt) begin
        next_st.xend = 1'b1; // [RULE9] [RULE13]
        next_st.mode = hbr_pkg::HBR_D_IDLE;
        next_st.irq_reg[hbr_pkg::IRQ_END_BIT] = 1'b1; // [RULE9]
        case (st.mode)
          hbr_pkg::HBR_D_ISO_WR: next_st.stat[hbr_pkg::ST_ISO0_FULL] = 1'b1;
          hbr_pkg::HBR_D_ISO_RD: next_st.stat[hbr_pkg::ST_ISO0_FULL] = 1'b0;
          hbr_pkg::HBR_D_ACK_WR: next_st.stat[hbr_pkg::ST_ACK_FULL]  = 1'b1;
          hbr_pkg::HBR_D_ACK_RD: next_st.stat[hbr_pkg::ST_ACK_FULL]  = 1'b0;
          default:               next_st.stat = next_st.stat;
        endcase
      end
    end

    // done flag: refill clears, controller read sets and wins
    if (ack_refilled) begin
      next_st.stat[hbr_pkg::ST_ACK_DONE] = 1'b0; // [RULE15]
    end
    if (ack_read_by_hc) begin
      next_st.stat[hbr_pkg::ST_ACK_DONE] = 1'b1; // [RULE15]
    end

    // a command aborts any transfer and restarts from the first byte
    if (link.cmd_stb) begin
      next_st.code = link.cmd_code;
      next_st.ptr  = hbr_pkg::ZERO16; // [RULE16]
      case (link.cmd_code)
        hbr_pkg::CMD_ISO_RD: next_st.mode = hbr_pkg::HBR_D_ISO_RD; // [RULE5]
        hbr_pkg::CMD_ISO_WR: next_st.mode = hbr_pkg::HBR_D_ISO_WR; // [RULE5]
        hbr_pkg::CMD_ACK_RD: next_st.mode = hbr_pkg::HBR_D_ACK_RD; // [RULE12]
        hbr_pkg::CMD_ACK_WR: next_st.mode = hbr_pkg::HBR_D_ACK_WR; // [RULE12]
        default:             next_st.mode = hbr_pkg::HBR_D_REG;
      endcase
    end
    next_st.irq = |next_st.irq_reg;
  end

  // clk stands for the core clock, the reference times the multiplier;
  // the multiplier lives outside this block [RULE14]
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.rd_data  = st.rdata;
  assign link.rd_valid = st.rvalid;
  assign link.irq      = st.irq;
  assign end_pulse     = st.xend;
  assign buf_status    = st.stat;
endmodule : hbr_device

// file: design/hbr_pkg.sv
// shared constants and types of the host buffer ram access ports
package hbr_pkg;
  // one-time command codes sent ahead of the data phase
  localparam logic [7:0] CMD_ISO_RD  = 8'h40;
  localparam logic [7:0] CMD_ISO_WR  = 8'hC0;
  localparam logic [7:0] CMD_ACK_RD  = 8'h41;
  localparam logic [7:0] CMD_ACK_WR  = 8'hC1;
  localparam logic [7:0] CMD_STAT_RD = 8'h2C;
  localparam logic [7:0] CMD_RB0_RD  = 8'h2D;
  localparam logic [7:0] CMD_RB1_RD  = 8'h2E;
  localparam logic [7:0] CMD_CNT_RD  = 8'h22;
  localparam logic [7:0] CMD_CNT_WR  = 8'hA2;
  localparam logic [7:0] CMD_IRQ_RD  = 8'h24;
  localparam logic [7:0] CMD_IRQ_WR  = 8'hA4;

  // buffer status bit positions
  localparam int ST_ISO0_FULL = 0;
  localparam int ST_ISO1_FULL = 1;
  localparam int ST_ACK_FULL  = 2;
  localparam int ST_ISO0_DONE = 3;
  localparam int ST_ISO1_DONE = 4;
  localparam int ST_ACK_DONE  = 5;
  localparam int ST_BITS      = 6;
  // processor interrupt register bit for all end-of-transfer
  localparam int IRQ_END_BIT  = 2;

  localparam logic [15:0] WORD_BYTES = 16'h0002;
  localparam logic [15:0] ZERO16     = 16'h0000;
  localparam int          RAM_BYTES  = 4096;

  // reference clock and on-chip multiplication to the core rate
  localparam int REF_CLK_MHZ  = 6;
  localparam int CORE_CLK_MHZ = 48;
  localparam int PLL_MULT     = CORE_CLK_MHZ / REF_CLK_MHZ;

  // host controller software registers
  localparam logic [3:0] HREG_START   = 4'h0;
  localparam logic [3:0] HREG_LEN     = 4'h1;
  localparam logic [3:0] HREG_DATA    = 4'h2;
  localparam logic [3:0] HREG_FETCH   = 4'h3;
  localparam logic [3:0] HREG_RDATA   = 4'h4;
  localparam logic [3:0] HREG_STATUS  = 4'h5;
  localparam logic [3:0] HREG_BUFSTAT = 4'h6;
  localparam int START_RB_BIT    = 8;
  localparam int START_WHICH_BIT = 9;

  typedef enum logic [2:0] {
    HBR_D_IDLE, HBR_D_ISO_RD, HBR_D_ISO_WR, HBR_D_ACK_RD, HBR_D_ACK_WR,
    HBR_D_REG
  } hbr_dmode_t;

  typedef enum logic [3:0] {
    HBR_H_IDLE, HBR_H_RB_CMD, HBR_H_RB_RD, HBR_H_RB_WAIT, HBR_H_CNT_CMD,
    HBR_H_CNT_WR, HBR_H_ST_CMD, HBR_H_ST_RD, HBR_H_ST_WAIT, HBR_H_PORT_CMD,
    HBR_H_STREAM
  } hbr_hstate_t;
endpackage : hbr_pkg

// file: design/hbr_link_if.sv
// command and data link between host driver end and buffer device end
`timescale 1ns/1ps
interface hbr_link_if;
  logic        cmd_stb;
  logic [7:0]  cmd_code;
  logic        wr_stb;
  logic [15:0] wr_data;
  logic        rd_stb;
  logic [15:0] rd_data;
  logic        rd_valid;
  logic        irq;

  modport dev  (input cmd_stb, cmd_code, wr_stb, wr_data, rd_stb,
                output rd_data, rd_valid, irq);
  modport host (output cmd_stb, cmd_code, wr_stb, wr_data, rd_stb,
                input rd_data, rd_valid, irq);
endinterface : hbr_link_if

// file: design/hbr_host.sv
// host driver end: software port, counter setup sequence, word stream
`timescale 1ns/1ps
module hbr_host (
  input  wire logic        clk,
  input  wire logic        resetn,
  hbr_link_if.host         link,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic [15:0]      sw_rdata
);
  typedef struct packed {
    hbr_pkg::hbr_hstate_t fsm;
    logic [7:0]           code;
    logic                 use_rb;
    logic                 which;
    logic [15:0]          len;
    logic [15:0]          words;
    logic [15:0]          last;
    logic [15:0]          bufstat;
    logic [15:0]          rdata;
    logic                 cmd_stb;
    logic [7:0]           cmd_code;
    logic                 wr_stb;
    logic [15:0]          wr_data;
    logic                 rd_stb;
  } hbr_hst_t;

  hbr_hst_t st;
  hbr_hst_t next_st;

  // one link strobe per cycle; software only moves words in STREAM
  always_comb begin
    next_st         = st;
    next_st.cmd_stb = 1'b0;
    next_st.wr_stb  = 1'b0;
    next_st.rd_stb  = 1'b0;
    next_st.rdata   = hbr_pkg::ZERO16;
    if (link.rd_valid) begin
      next_st.last = link.rd_data;
    end
    if (sw_wr && sw_addr == hbr_pkg::HREG_LEN &&
        st.fsm == hbr_pkg::HBR_H_IDLE) begin
      next_st.len = sw_wdata;
    end
    case (st.fsm)
      hbr_pkg::HBR_H_IDLE: begin
        if (sw_wr && sw_addr == hbr_pkg::HREG_START) begin
          next_st.code   = sw_wdata[7:0];
          next_st.use_rb = sw_wdata[hbr_pkg::START_RB_BIT];
          next_st.which  = sw_wdata[hbr_pkg::START_WHICH_BIT];
          next_st.fsm    = sw_wdata[hbr_pkg::START_RB_BIT] ?
                           hbr_pkg::HBR_H_RB_CMD : hbr_pkg::HBR_H_CNT_CMD;
        end
      end
      hbr_pkg::HBR_H_RB_CMD: begin
        next_st.cmd_stb  = 1'b1;
        next_st.cmd_code = st.which ? hbr_pkg::CMD_RB1_RD
                                    : hbr_pkg::CMD_RB0_RD;
        next_st.fsm      = hbr_pkg::HBR_H_RB_RD;
      end
      hbr_pkg::HBR_H_RB_RD: begin
        next_st.rd_stb = 1'b1;
        next_st.fsm    = hbr_pkg::HBR_H_RB_WAIT;
      end
      hbr_pkg::HBR_H_RB_WAIT: begin
        if (link.rd_valid) begin
          next_st.len = link.rd_data; // counter takes readback [RULE3]
          next_st.fsm = hbr_pkg::HBR_H_CNT_CMD;
        end
      end
      hbr_pkg::HBR_H_CNT_CMD: begin
        next_st.cmd_stb  = 1'b1;
        next_st.cmd_code = hbr_pkg::CMD_CNT_WR; // [RULE6]
        next_st.fsm      = hbr_pkg::HBR_H_CNT_WR;
      end
      hbr_pkg::HBR_H_CNT_WR: begin
        next_st.wr_stb  = 1'b1;
        next_st.wr_data = st.len; // byte count [RULE10]
        next_st.fsm     = hbr_pkg::HBR_H_ST_CMD;
      end
      hbr_pkg::HBR_H_ST_CMD: begin
        next_st.cmd_stb  = 1'b1;
        next_st.cmd_code = hbr_pkg::CMD_STAT_RD; // [RULE6]
        next_st.fsm      = hbr_pkg::HBR_H_ST_RD;
      end
      hbr_pkg::HBR_H_ST_RD: begin
        next_st.rd_stb = 1'b1;
        next_st.fsm    = hbr_pkg::HBR_H_ST_WAIT;
      end
      hbr_pkg::HBR_H_ST_WAIT: begin
        if (link.rd_valid) begin
          next_st.bufstat = link.rd_data;
          next_st.fsm     = hbr_pkg::HBR_H_PORT_CMD;
        end
      end
      hbr_pkg::HBR_H_PORT_CMD: begin
        // issued once; words then follow with no repeat [RULE7]
        next_st.cmd_stb  = 1'b1;
        next_st.cmd_code = st.code; // [RULE5] [RULE12]
        next_st.words    = 16'((17'(st.len) + 17'h00001) >> 1); // [RULE10]
        next_st.fsm      = (st.len == hbr_pkg::ZERO16) ?
                           hbr_pkg::HBR_H_IDLE : hbr_pkg::HBR_H_STREAM;
      end
      hbr_pkg::HBR_H_STREAM: begin
        if (sw_wr && sw_addr == hbr_pkg::HREG_DATA) begin
          next_st.wr_stb  = 1'b1;
          next_st.wr_data = sw_wdata;
        end else if (sw_wr && sw_addr == hbr_pkg::HREG_FETCH) begin
          next_st.rd_stb = 1'b1;
        end
        if (sw_wr && (sw_addr == hbr_pkg::HREG_DATA ||
                      sw_addr == hbr_pkg::HREG_FETCH)) begin
          next_st.words = st.words - 16'h0001;
          if (st.words == 16'h0001) begin
            next_st.fsm = hbr_pkg::HBR_H_IDLE;
          end
        end
      end
      default: next_st.fsm = hbr_pkg::HBR_H_IDLE;
    endcase
    // software read data stand only in the cycle after the strobe
    if (sw_rd) begin
      case (sw_addr)
        hbr_pkg::HREG_LEN:     next_st.rdata = st.len;
        hbr_pkg::HREG_RDATA:   next_st.rdata = st.last;
        hbr_pkg::HREG_STATUS:  next_st.rdata = {link.irq,
                                 st.fsm != hbr_pkg::HBR_H_IDLE,
                                 14'(st.words)};
        hbr_pkg::HREG_BUFSTAT: next_st.rdata = st.bufstat;
        default:               next_st.rdata = hbr_pkg::ZERO16;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign link.cmd_stb  = st.cmd_stb;
  assign link.cmd_code = st.cmd_code;
  assign link.wr_stb   = st.wr_stb;
  assign link.wr_data  = st.wr_data;
  assign link.rd_stb   = st.rd_stb;
  assign sw_rdata      = st.rdata;
endmodule : hbr_host

// file: sim/hbr_link_checker.sv
// link checker: setup order, read answers and end-of-transfer timing
`timescale 1ns/1ps
module hbr_link_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        cmd_stb,
  input wire logic [7:0]  cmd_code,
  input wire logic        wr_stb,
  input wire logic [15:0] wr_data,
  input wire logic        rd_stb,
  input wire logic [15:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        irq
);
  logic [7:0]  last_cmd;
  logic [15:0] len;
  logic [15:0] words;
  logic        streaming;
  logic        cnt_next;
  logic        is_port;
  logic        strobe;
  logic        last_word;

  // a word ends the transfer once the bytes it covers reach the count
  assign is_port   = cmd_code inside {hbr_pkg::CMD_ISO_RD, hbr_pkg::CMD_ISO_WR,
                                      hbr_pkg::CMD_ACK_RD, hbr_pkg::CMD_ACK_WR};
  assign strobe    = streaming && (wr_stb || rd_stb);
  assign last_word = strobe && ({words, 1'b0} + 17'h00002 >= {1'b0, len});

  // track last command, programmed byte count and words moved
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last_cmd  <= 8'h00;
      len       <= 16'h0000;
      words     <= 16'h0000;
      streaming <= 1'b0;
      cnt_next  <= 1'b0;
    end else begin
      if (cmd_stb) last_cmd <= cmd_code;
      cnt_next <= cmd_stb && cmd_code == hbr_pkg::CMD_CNT_WR;
      if (cnt_next && wr_stb) len <= wr_data;
      if (cmd_stb && is_port) begin
        streaming <= 1'b1;
        words     <= 16'h0000;
      end else if (strobe) begin
        words <= words + 16'h0001;
        if (last_word) streaming <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_rb_read;
    cmd_stb && (cmd_code == hbr_pkg::CMD_RB0_RD ||
                cmd_code == hbr_pkg::CMD_RB1_RD) ##1 rd_stb ##1 rd_valid;
  endsequence
  sequence s_cnt_cmd;
    cmd_stb && cmd_code == hbr_pkg::CMD_CNT_WR;
  endsequence

  property p_cnt_from_rb;
    s_rb_read ##2 s_cnt_cmd |=> wr_stb && wr_data == $past(rd_data, 3);
  endproperty
  property p_cnt_then_wr;
    s_cnt_cmd |=> wr_stb && !cmd_stb;
  endproperty
  property p_stat_first;
    cmd_stb && is_port |-> last_cmd == hbr_pkg::CMD_STAT_RD;
  endproperty
  property p_rd_answer;
    rd_stb |=> rd_valid;
  endproperty
  property p_valid_cause;
    rd_valid |-> $past(rd_stb);
  endproperty
  property p_rd_quiet;
    !rd_valid |-> rd_data == 16'h0000;
  endproperty
  property p_cmd_once;
    streaming |-> !cmd_stb;
  endproperty
  property p_end_at_count;
    last_word |=> irq;
  endproperty
  property p_no_early;
    strobe && !last_word |=> !$rose(irq);
  endproperty

  a_cnt_from_rb: assert property (p_cnt_from_rb)
    else $error("counter not loaded from readback length");
  a_cnt_then_wr: assert property (p_cnt_then_wr)
    else $error("counter command without its data word");
  a_stat_first: assert property (p_stat_first)
    else $error("port opened without status read");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read strobe not answered");
  a_valid_cause: assert property (p_valid_cause)
    else $error("read valid without read strobe");
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data not zero outside valid");
  a_cmd_once: assert property (p_cmd_once)
    else $error("command repeated inside a transfer");
  a_end_at_count: assert property (p_end_at_count)
    else $error("no end of transfer at count");
  a_no_early: assert property (p_no_early)
    else $error("end of transfer before count");
endmodule : hbr_link_checker

// file: sim/test_host_buffer_ram_access_ports.sv
// self-checking bench: host end drives device end over the link
`timescale 1ns/1ps
module test_host_buffer_ram_access_ports;
  localparam int DEPTH = 64;
  logic        clk        = 1'b0;
  logic        resetn     = 1'b0;
  logic [3:0]  sw_addr    = 4'h0;
  logic [15:0] sw_wdata   = 16'h0000;
  logic        sw_wr      = 1'b0;
  logic        sw_rd      = 1'b0;
  logic [15:0] pend0      = 16'h0000;
  logic [15:0] pend1      = 16'h0000;
  logic        ack_rd     = 1'b0;
  logic        ack_fill   = 1'b0;
  logic [15:0] seen_cnt   = 16'h0000;
  logic        cnt_next   = 1'b0;
  logic [15:0] sw_rdata;
  logic        end_pulse;
  logic [5:0]  buf_status;
  int          err_count  = 0;
  int          n_checks   = 0;
  int          end_n      = 0;
  int          cycles     = 0;
  int          seed       = 32'h9E0569CF;
  int          mdl[2][DEPTH/2]; // words per port: 0 iso, 1 ack

  hbr_link_if link ();
  hbr_device #(.DEPTH(DEPTH)) i_hbr_device (.clk(clk), .resetn(resetn),
    .link(link), .iso0_pending_bytes(pend0), .iso1_pending_bytes(pend1),
    .ack_read_by_hc(ack_rd), .ack_refilled(ack_fill),
    .end_pulse(end_pulse), .buf_status(buf_status));
  hbr_host i_hbr_host (.clk(clk), .resetn(resetn), .link(link),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata));
  hbr_link_checker i_hbr_link_checker (.clk(clk), .resetn(resetn),
    .cmd_stb(link.cmd_stb), .cmd_code(link.cmd_code), .wr_stb(link.wr_stb),
    .wr_data(link.wr_data), .rd_stb(link.rd_stb), .rd_data(link.rd_data),
    .rd_valid(link.rd_valid), .irq(link.irq));

  always #12.5 clk = ~clk;

  // watch the link for the counter word, count events, cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (end_pulse === 1'b1) end_n++;
    cnt_next <= link.cmd_stb && link.cmd_code == hbr_pkg::CMD_CNT_WR;
    if (cnt_next && link.wr_stb) seen_cnt <= link.wr_data;
    if (cycles > 20000) begin
      err_count++;
      results();
    end
  end

  task automatic results();
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask : sw_write

  task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_read

  // poll busy under a bound; returns the last status word
  task automatic wait_idle(output logic [15:0] d);
    for (int i = 0; i < 40; i++) begin
      sw_read(hbr_pkg::HREG_STATUS, d);
      if (d[14] === 1'b0) break;
    end
    chk({15'h0000, d[14]}, 16'h0000);
  endtask : wait_idle

  // start a setup, then let the fixed setup walk finish before words
  task automatic start(input int len, input logic [15:0] ctl);
    if (ctl[8] == 1'b0) sw_write(hbr_pkg::HREG_LEN, len[15:0]);
    sw_write(hbr_pkg::HREG_START, ctl);
    repeat (12) @(posedge clk);
  endtask : start

  // register read by code: one fetch in the port walk, then the copy
  task automatic reg_rd(input logic [7:0] c, input int n,
                        output logic [15:0] d);
    start(n, {8'h00, c});
    sw_write(hbr_pkg::HREG_FETCH, 16'h0000);
    @(posedge clk);
    sw_read(hbr_pkg::HREG_RDATA, d);
  endtask : reg_rd

  // one whole port transfer, then end-of-transfer checks and irq clear
  task automatic xfer(input int p, input bit rd, input int len,
                      input logic [7:0] rb);
    logic [7:0]  code;
    logic [15:0] d;
    int          e0;
    int          r;
    code = p ? (rd ? hbr_pkg::CMD_ACK_RD : hbr_pkg::CMD_ACK_WR)
             : (rd ? hbr_pkg::CMD_ISO_RD : hbr_pkg::CMD_ISO_WR);
    e0 = end_n;
    start(len, {rb, code});
    for (int i = 0; i < (len + 1) / 2; i++) begin
      if (rd) begin
        sw_write(hbr_pkg::HREG_FETCH, 16'h0000);
        @(posedge clk);
        sw_read(hbr_pkg::HREG_RDATA, d);
        chk(d, mdl[p][i][15:0]);
      end else begin
        r = $random(seed);
        mdl[p][i] = r & 32'h0000FFFF;
        sw_write(hbr_pkg::HREG_DATA, r[15:0]);
      end
    end
    wait_idle(d);
    chk(seen_cnt, len[15:0]);
    chk({15'h0000, d[15]}, 16'h0001);
    chk(16'(end_n - e0), 16'h0001);
    if (!rd) begin
      r = p ? hbr_pkg::ST_ACK_FULL : hbr_pkg::ST_ISO0_FULL;
      chk({15'h0000, buf_status[r]}, 16'h0001);
      // first byte of the buffer sits in the lane its port names
      r = p ? mdl[1][0][7:0] : mdl[0][0][15:8];
      e0 = p ? i_hbr_device.st.ack_mem[0] : i_hbr_device.st.iso_mem[0];
      chk(16'(e0), 16'(r));
    end
    // the end bit reads back through the register command as well
    reg_rd(hbr_pkg::CMD_IRQ_RD, 2, d);
    chk(d, 16'h0004);
    // write-1-clear of the end-of-transfer bit through a register command
    start(2, {8'h00, hbr_pkg::CMD_IRQ_WR});
    sw_write(hbr_pkg::HREG_DATA, 16'h0004);
    wait_idle(d);
    chk({15'h0000, d[15]}, 16'h0000);
  endtask : xfer

  initial begin
    logic [15:0] d;
    int          r;
    int          len;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    sw_read(hbr_pkg::HREG_LEN, d);
    chk(d, 16'h0000);
    sw_read(hbr_pkg::HREG_RDATA, d);
    chk(d, 16'h0000);
    // the byte counter reads back what the setup walk wrote
    reg_rd(hbr_pkg::CMD_CNT_RD, 1, d);
    chk(d, 16'h0001);
    // full-size then random odd or even lengths on both ports
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      len = (k < 2) ? DEPTH : 1 + int'(r[15:0]) % DEPTH;
      xfer(k % 2, 1'b0, len, 8'h00);
      xfer(k % 2, 1'b1, len, 8'h00);
    end
    // read back with counts taken from each iso pending register
    @(posedge clk);
    pend0 <= 16'(DEPTH - 2);
    pend1 <= 16'(DEPTH / 2 + 1);
    xfer(0, 1'b1, DEPTH - 2, 8'h01);
    xfer(0, 1'b1, DEPTH / 2 + 1, 8'h03);
    // ack done flag follows the read and refill pulses
    @(posedge clk) ack_rd <= 1'b1;
    @(posedge clk) ack_rd <= 1'b0;
    @(posedge clk) #1;
    chk({15'h0000, buf_status[hbr_pkg::ST_ACK_DONE]}, 16'h0001);
    @(posedge clk) ack_fill <= 1'b1;
    @(posedge clk) ack_fill <= 1'b0;
    @(posedge clk) #1;
    chk({15'h0000, buf_status[hbr_pkg::ST_ACK_DONE]}, 16'h0000);
    // read and refill in one cycle: the read wins
    @(posedge clk);
    ack_rd   <= 1'b1;
    ack_fill <= 1'b1;
    @(posedge clk);
    ack_rd   <= 1'b0;
    ack_fill <= 1'b0;
    @(posedge clk) #1;
    chk({15'h0000, buf_status[hbr_pkg::ST_ACK_DONE]}, 16'h0001);
    results();
  end
endmodule : test_host_buffer_ram_access_ports
